// [common/tsf_pkg.sv]
// ==========================================================
// Time setpoint and flag constants.
package tsf_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SEC_W  = 6;
  localparam int MIN_W  = 6;
  localparam int HOUR_W = 5;
  localparam int DAY_W  = 5;
  localparam int WDAY_W = 3;
  localparam int NUM_WDAY  = 7;
  localparam int NUM_DAILY = 2;
  localparam int NUM_CMD   = 7;
  localparam int NUM_AUX   = 16;
  localparam int NUM_CAN   = 5;
  localparam int NUM_LED   = 8;

  // ==========================================================
  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFS_TIMER1  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TIMER2  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_ACTDAY  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_ACTHOUR = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_ACTMIN  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_ACTSEC  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_WDAYEN  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CMDVAR  = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_FLAGS   = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_RTC     = 8'h24;
  localparam logic [ADDR_W-1:0] TIMER_STEP  = 8'h04;

  // ==========================================================
  // Field positions.
  localparam int SEC_LSB  = 0;
  localparam int MIN_LSB  = 8;
  localparam int HOUR_LSB = 16;
  localparam int WDAY_LSB = 24;
  localparam int DAY_LSB  = 24;
  localparam int CAN_LSB  = 16;
  localparam int LED_LSB  = 24;

  // ==========================================================
  // Ranges and reset values.
  localparam logic [SEC_W-1:0]    SEC_MAX      = 6'h3b;
  localparam logic [MIN_W-1:0]    MIN_MAX      = 6'h3b;
  localparam logic [HOUR_W-1:0]   HOUR_MAX     = 5'h17;
  localparam logic [DAY_W-1:0]    DAY_MIN      = 5'h01;
  localparam logic [WDAY_W-1:0]   WDAY_MAX     = 3'h6;
  localparam logic [HOUR_W-1:0]   T1_HOUR_RST  = 5'h08;
  localparam logic [HOUR_W-1:0]   T2_HOUR_RST  = 5'h11;
  localparam logic [MIN_W-1:0]    MIN_RST      = 6'h00;
  localparam logic [SEC_W-1:0]    SEC_RST      = 6'h00;
  localparam logic [DAY_W-1:0]    ACTDAY_RST   = 5'h01;
  localparam logic [HOUR_W-1:0]   ACTHOUR_RST  = 5'h0c;
  localparam logic [NUM_WDAY-1:0] WDAYEN_RST   = 7'h1f;

  // ==========================================================
  // Command variable positions.
  localparam int CMD_TMR1 = 0;
  localparam int CMD_WDAY = 2;
  localparam int CMD_DAY  = 3;
  localparam int CMD_HOUR = 4;
  localparam int CMD_MIN  = 5;
  localparam int CMD_SEC  = 6;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tsf_pkg

// [hw/tsf_daily_cmp.sv]
`timescale 1ns/1ps
// ==========================================================
// Time-of-day comparator for one daily setpoint.
module tsf_daily_cmp (
  input  wire logic [tsf_pkg::HOUR_W-1:0] curHour,
  input  wire logic [tsf_pkg::MIN_W-1:0]  curMin,
  input  wire logic [tsf_pkg::SEC_W-1:0]  curSec,
  input  wire logic [tsf_pkg::HOUR_W-1:0] setHour,
  input  wire logic [tsf_pkg::MIN_W-1:0]  setMin,
  input  wire logic [tsf_pkg::SEC_W-1:0]  setSec,
  output logic                            hit
);
  // A plain compare needs no latch: the result drops at midnight by itself.
  always_comb
  begin
    hit = {curHour, curMin, curSec} >= {setHour, setMin, setSec};
  end
endmodule : tsf_daily_cmp

// [hw/tsf_time_setpoint.sv]
`timescale 1ns/1ps
module tsf_time_setpoint (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          ce,
  input  wire logic [tsf_pkg::SEC_W-1:0]     rtcSec,
  input  wire logic [tsf_pkg::MIN_W-1:0]     rtcMin,
  input  wire logic [tsf_pkg::HOUR_W-1:0]    rtcHour,
  input  wire logic [tsf_pkg::WDAY_W-1:0]    rtcWeekday,
  input  wire logic [tsf_pkg::DAY_W-1:0]     rtcDay,
  input  wire logic [tsf_pkg::NUM_AUX-1:0]   auxFlagExpr,
  input  wire logic [tsf_pkg::NUM_CAN-1:0]   canFlagExpr,
  input  wire logic [tsf_pkg::NUM_LED-1:0]   ledFlagExpr,
  input  wire logic                          metalHousing,
  output logic      [tsf_pkg::NUM_CMD-1:0]   cmdVar,
  output logic      [tsf_pkg::NUM_AUX-1:0]   auxFlag,
  output logic      [tsf_pkg::NUM_CAN-1:0]   canSharedFlag,
  output logic      [tsf_pkg::NUM_LED-1:0]   ledAuxFlag,
  output logic      [tsf_pkg::NUM_LED-1:0]   ledDriveFlag,
  input  wire logic [tsf_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [tsf_pkg::DATA_W-1:0]    s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic      [1:0]                    s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [tsf_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic      [tsf_pkg::DATA_W-1:0]    s_axi_rdata,
  output logic      [1:0]                    s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready
);
  localparam int HW = tsf_pkg::HOUR_W;
  localparam int MW = tsf_pkg::MIN_W;
  localparam int SW = tsf_pkg::SEC_W;
  localparam int DW = tsf_pkg::DATA_W;
  localparam int ND = tsf_pkg::NUM_DAILY;

  // ==========================================================
  // Helpers.
  function automatic logic [DW-1:0] packTime(
    input logic [HW-1:0] h, input logic [MW-1:0] m, input logic [SW-1:0] s);
    logic [DW-1:0] v;
    v = '0;
    v[tsf_pkg::HOUR_LSB +: HW] = h;
    v[tsf_pkg::MIN_LSB +: MW] = m;
    v[tsf_pkg::SEC_LSB +: SW] = s;
    return v;
  endfunction : packTime

  function automatic logic [DW-1:0] mergeStrb(
    input logic [DW-1:0] old, input logic [DW-1:0] dat, input logic [3:0] strb);
    logic [DW-1:0] v;
    v = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        v[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
    return v;
  endfunction : mergeStrb

  // ==========================================================
  // State.
  logic [SW-1:0]               curSec_ff, nxt_curSec;
  logic [MW-1:0]               curMin_ff, nxt_curMin;
  logic [HW-1:0]               curHour_ff, nxt_curHour;
  logic [tsf_pkg::WDAY_W-1:0]  curWday_ff, nxt_curWday;
  logic [tsf_pkg::DAY_W-1:0]   curDay_ff, nxt_curDay;
  logic [HW-1:0]               tHour_ff [ND];
  logic [MW-1:0]               tMin_ff [ND];
  logic [SW-1:0]               tSec_ff [ND];
  logic [HW-1:0]               nxt_tHour [ND];
  logic [MW-1:0]               nxt_tMin [ND];
  logic [SW-1:0]               nxt_tSec [ND];
  logic [tsf_pkg::DAY_W-1:0]   actDay_ff, nxt_actDay;
  logic [HW-1:0]               actHour_ff, nxt_actHour;
  logic [MW-1:0]               actMin_ff, nxt_actMin;
  logic [SW-1:0]               actSec_ff, nxt_actSec;
  logic [tsf_pkg::NUM_WDAY-1:0] wdayEn_ff, nxt_wdayEn;
  logic                        metal_ff;
  logic [tsf_pkg::NUM_CMD-1:0] cmdVar_ff, nxt_cmdVar;
  logic [tsf_pkg::NUM_AUX-1:0] aux_ff, nxt_aux;
  logic [tsf_pkg::NUM_CAN-1:0] can_ff, nxt_can;
  logic [tsf_pkg::NUM_LED-1:0] ledAux_ff, nxt_ledAux;
  logic [tsf_pkg::NUM_LED-1:0] ledDrv_ff, nxt_ledDrv;
  logic [ND-1:0]               dailyHit;
  logic                        awHeld_ff, nxt_awHeld, wHeld_ff, nxt_wHeld;
  logic [tsf_pkg::ADDR_W-1:0]  awAddr_ff, nxt_awAddr;
  logic [DW-1:0]               wData_ff, nxt_wData;
  logic [3:0]                  wStrb_ff, nxt_wStrb;
  logic                        awready_ff, nxt_awready, wready_ff, nxt_wready;
  logic                        bvalid_ff, nxt_bvalid, arready_ff, nxt_arready;
  logic                        rvalid_ff, nxt_rvalid;
  logic [1:0]                  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [DW-1:0]               rdata_ff, nxt_rdata;

  // ==========================================================
  // Comparators.
  genvar gi;
  generate
    for (gi = 0; gi < ND; gi++)
    begin : g_daily
      tsf_daily_cmp u_cmp (
        .curHour (curHour_ff),
        .curMin  (curMin_ff),
        .curSec  (curSec_ff),
        .setHour (tHour_ff[gi]),
        .setMin  (tMin_ff[gi]),
        .setSec  (tSec_ff[gi]),
        .hit     (dailyHit[gi])
      );
    end
  endgenerate

  always_comb
  begin
    nxt_curSec  = rtcSec;
    nxt_curMin  = rtcMin;
    nxt_curHour = rtcHour;
    nxt_curWday = rtcWeekday;
    nxt_curDay  = rtcDay;
    nxt_cmdVar  = '0;
    nxt_cmdVar[tsf_pkg::CMD_TMR1 +: ND] = dailyHit;
    nxt_cmdVar[tsf_pkg::CMD_WDAY] = (curWday_ff <= tsf_pkg::WDAY_MAX) &&
                                    wdayEn_ff[curWday_ff];
    nxt_cmdVar[tsf_pkg::CMD_DAY]  = curDay_ff == actDay_ff;
    nxt_cmdVar[tsf_pkg::CMD_HOUR] = curHour_ff == actHour_ff;
    nxt_cmdVar[tsf_pkg::CMD_MIN]  = curMin_ff == actMin_ff;
    nxt_cmdVar[tsf_pkg::CMD_SEC]  = curSec_ff == actSec_ff;
    nxt_aux    = auxFlagExpr;
    nxt_can    = canFlagExpr;
    nxt_ledAux = ledFlagExpr;
    // The variant is strapped; it is caught once, during reset.
    nxt_ledDrv = metal_ff ? ledFlagExpr : '0;
  end

  // ==========================================================
  // Register bus.
  always_comb
  begin
    logic          awHs;
    logic          wHs;
    logic          doWr;
    logic [DW-1:0] m;
    int            ti;
    awHs = s_axi_awvalid && awready_ff;
    wHs  = s_axi_wvalid && wready_ff;
    doWr = awHeld_ff && wHeld_ff && !bvalid_ff;
    m    = '0;
    ti   = 0;
    nxt_awAddr = awHs ? s_axi_awaddr : awAddr_ff;
    nxt_wData  = wHs ? s_axi_wdata : wData_ff;
    nxt_wStrb  = wHs ? s_axi_wstrb : wStrb_ff;
    nxt_awHeld = (awHeld_ff || awHs) && !doWr;
    nxt_wHeld  = (wHeld_ff || wHs) && !doWr;
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    nxt_tHour  = tHour_ff;
    nxt_tMin   = tMin_ff;
    nxt_tSec   = tSec_ff;
    nxt_actDay  = actDay_ff;
    nxt_actHour = actHour_ff;
    nxt_actMin  = actMin_ff;
    nxt_actSec  = actSec_ff;
    nxt_wdayEn  = wdayEn_ff;
    if (bvalid_ff && s_axi_bready)
    begin
      nxt_bvalid = 1'b0;
    end
    if (doWr)
    begin
      nxt_bvalid = 1'b1;
      nxt_bresp  = tsf_pkg::RESP_OKAY;
      // Out-of-range values are dropped whole so a register never holds
      // a time that the clock can never reach.
      case (awAddr_ff)
        tsf_pkg::OFS_TIMER1, tsf_pkg::OFS_TIMER2:
        begin
          ti = (awAddr_ff == tsf_pkg::OFS_TIMER2) ? 1 : 0;
          m = mergeStrb(packTime(tHour_ff[ti], tMin_ff[ti], tSec_ff[ti]),
                        wData_ff, wStrb_ff);
          if (m[tsf_pkg::HOUR_LSB +: HW] <= tsf_pkg::HOUR_MAX &&
              m[tsf_pkg::MIN_LSB +: MW] <= tsf_pkg::MIN_MAX &&
              m[tsf_pkg::SEC_LSB +: SW] <= tsf_pkg::SEC_MAX)
          begin
            nxt_tHour[ti] = m[tsf_pkg::HOUR_LSB +: HW];
            nxt_tMin[ti]  = m[tsf_pkg::MIN_LSB +: MW];
            nxt_tSec[ti]  = m[tsf_pkg::SEC_LSB +: SW];
          end
        end
        tsf_pkg::OFS_ACTDAY:
        begin
          m = mergeStrb(DW'(actDay_ff), wData_ff, wStrb_ff);
          if (m[tsf_pkg::DAY_W-1:0] >= tsf_pkg::DAY_MIN)
          begin
            nxt_actDay = m[tsf_pkg::DAY_W-1:0];
          end
        end
        tsf_pkg::OFS_ACTHOUR:
        begin
          m = mergeStrb(DW'(actHour_ff), wData_ff, wStrb_ff);
          if (m[HW-1:0] <= tsf_pkg::HOUR_MAX)
          begin
            nxt_actHour = m[HW-1:0];
          end
        end
        tsf_pkg::OFS_ACTMIN:
        begin
          m = mergeStrb(DW'(actMin_ff), wData_ff, wStrb_ff);
          if (m[MW-1:0] <= tsf_pkg::MIN_MAX)
          begin
            nxt_actMin = m[MW-1:0];
          end
        end
        tsf_pkg::OFS_ACTSEC:
        begin
          m = mergeStrb(DW'(actSec_ff), wData_ff, wStrb_ff);
          if (m[SW-1:0] <= tsf_pkg::SEC_MAX)
          begin
            nxt_actSec = m[SW-1:0];
          end
        end
        tsf_pkg::OFS_WDAYEN:
        begin
          m = mergeStrb(DW'(wdayEn_ff), wData_ff, wStrb_ff);
          nxt_wdayEn = m[tsf_pkg::NUM_WDAY-1:0];
        end
        tsf_pkg::OFS_CMDVAR, tsf_pkg::OFS_FLAGS, tsf_pkg::OFS_RTC:
        begin
          nxt_bresp = tsf_pkg::RESP_OKAY;
        end
        default:
        begin
          nxt_bresp = tsf_pkg::RESP_SLVERR;
        end
      endcase
    end
    nxt_awready = !nxt_awHeld && !nxt_bvalid;
    nxt_wready  = !nxt_wHeld && !nxt_bvalid;
  end

  always_comb
  begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (rvalid_ff && s_axi_rready)
    begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid && arready_ff)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = tsf_pkg::RESP_OKAY;
      nxt_rdata  = '0;
      case (s_axi_araddr)
        tsf_pkg::OFS_TIMER1: nxt_rdata = packTime(tHour_ff[0], tMin_ff[0], tSec_ff[0]);
        tsf_pkg::OFS_TIMER2: nxt_rdata = packTime(tHour_ff[1], tMin_ff[1], tSec_ff[1]);
        tsf_pkg::OFS_ACTDAY:  nxt_rdata = DW'(actDay_ff);
        tsf_pkg::OFS_ACTHOUR: nxt_rdata = DW'(actHour_ff);
        tsf_pkg::OFS_ACTMIN:  nxt_rdata = DW'(actMin_ff);
        tsf_pkg::OFS_ACTSEC:  nxt_rdata = DW'(actSec_ff);
        tsf_pkg::OFS_WDAYEN:  nxt_rdata = DW'(wdayEn_ff);
        tsf_pkg::OFS_CMDVAR:  nxt_rdata = DW'(cmdVar_ff);
        tsf_pkg::OFS_FLAGS:
        begin
          nxt_rdata[tsf_pkg::NUM_AUX-1:0] = aux_ff;
          nxt_rdata[tsf_pkg::CAN_LSB +: tsf_pkg::NUM_CAN] = can_ff;
          nxt_rdata[tsf_pkg::LED_LSB +: tsf_pkg::NUM_LED] = ledAux_ff;
        end
        tsf_pkg::OFS_RTC:
        begin
          nxt_rdata = packTime(curHour_ff, curMin_ff, curSec_ff);
          nxt_rdata[tsf_pkg::WDAY_LSB +: tsf_pkg::WDAY_W] = curWday_ff;
        end
        default: nxt_rresp = tsf_pkg::RESP_SLVERR;
      endcase
    end
    nxt_arready = !nxt_rvalid;
  end

  // ==========================================================
  // Registers.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      curSec_ff <= '0;
      curMin_ff <= '0;
      curHour_ff <= '0;
      curWday_ff <= '0;
      curDay_ff <= '0;
      tHour_ff[0] <= tsf_pkg::T1_HOUR_RST;
      tHour_ff[1] <= tsf_pkg::T2_HOUR_RST;
      for (int i = 0; i < ND; i++)
      begin
        tMin_ff[i] <= tsf_pkg::MIN_RST;
        tSec_ff[i] <= tsf_pkg::SEC_RST;
      end
      actDay_ff <= tsf_pkg::ACTDAY_RST;
      actHour_ff <= tsf_pkg::ACTHOUR_RST;
      actMin_ff <= tsf_pkg::MIN_RST;
      actSec_ff <= tsf_pkg::SEC_RST;
      wdayEn_ff <= tsf_pkg::WDAYEN_RST;
      metal_ff <= metalHousing;
      cmdVar_ff <= '0;
      aux_ff <= '0;
      can_ff <= '0;
      ledAux_ff <= '0;
      ledDrv_ff <= '0;
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      awAddr_ff <= '0;
      wData_ff <= '0;
      wStrb_ff <= '0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= tsf_pkg::RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= tsf_pkg::RESP_OKAY;
      rdata_ff <= '0;
    end
    else if (ce)
    begin
      curSec_ff <= nxt_curSec;
      curMin_ff <= nxt_curMin;
      curHour_ff <= nxt_curHour;
      curWday_ff <= nxt_curWday;
      curDay_ff <= nxt_curDay;
      tHour_ff <= nxt_tHour;
      tMin_ff <= nxt_tMin;
      tSec_ff <= nxt_tSec;
      actDay_ff <= nxt_actDay;
      actHour_ff <= nxt_actHour;
      actMin_ff <= nxt_actMin;
      actSec_ff <= nxt_actSec;
      wdayEn_ff <= nxt_wdayEn;
      cmdVar_ff <= nxt_cmdVar;
      aux_ff <= nxt_aux;
      can_ff <= nxt_can;
      ledAux_ff <= nxt_ledAux;
      ledDrv_ff <= nxt_ledDrv;
      awHeld_ff <= nxt_awHeld;
      wHeld_ff <= nxt_wHeld;
      awAddr_ff <= nxt_awAddr;
      wData_ff <= nxt_wData;
      wStrb_ff <= nxt_wStrb;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
    end
  end

  assign cmdVar        = cmdVar_ff;
  assign auxFlag       = aux_ff;
  assign canSharedFlag = can_ff;
  assign ledAuxFlag    = ledAux_ff;
  assign ledDriveFlag  = ledDrv_ff;
  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;

  // ==========================================================
  // Assertions.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_daily_on;
    $past(ce) && $past(curHour_ff == tHour_ff[0] && curMin_ff == tMin_ff[0] &&
                       curSec_ff == tSec_ff[0]) |-> cmdVar_ff[0];
  endproperty
  a_daily_on: assert property (p_daily_on) else $error("timer 1 not set at time");

  property p_daily_off;
    $past(ce) && $past(curHour_ff < tHour_ff[1]) |-> !cmdVar_ff[1];
  endproperty
  a_daily_off: assert property (p_daily_off) else $error("timer 2 set early");

  property p_hour_range;
    tHour_ff[0] <= tsf_pkg::HOUR_MAX && tHour_ff[1] <= tsf_pkg::HOUR_MAX;
  endproperty
  a_hour_range: assert property (p_hour_range) else $error("timer hour range");

  property p_t_rst;
    $rose(rst_n) |-> tHour_ff[0] == 5'h08 && tHour_ff[1] == 5'h11 &&
                     tMin_ff[0] == 6'h00 && tSec_ff[1] == 6'h00 &&
                     actHour_ff == 5'h0c && actDay_ff == 5'h01;
  endproperty
  a_t_rst: assert property (p_t_rst) else $error("setpoint reset value");

  property p_ms_range;
    tMin_ff[0] <= 6'h3b && tMin_ff[1] <= 6'h3b && tSec_ff[0] <= 6'h3b &&
    tSec_ff[1] <= 6'h3b && actMin_ff <= 6'h3b && actSec_ff <= 6'h3b;
  endproperty
  a_ms_range: assert property (p_ms_range) else $error("min or sec range");

  property p_day;
    $past(ce) && $past(rst_n) |-> cmdVar_ff[3] == ($past(curDay_ff) == $past(actDay_ff));
  endproperty
  a_day: assert property (p_day) else $error("day output wrong");

  property p_hms;
    $past(ce) && $past(rst_n) && $past(curHour_ff != actHour_ff) &&
      $past(curSec_ff == actSec_ff) |-> !cmdVar_ff[4] && cmdVar_ff[6];
  endproperty
  a_hms: assert property (p_hms) else $error("hour or second output wrong");

  property p_wday;
    $past(ce) && $past(curWday_ff) == 3'h5 |-> cmdVar_ff[2] == $past(wdayEn_ff[5]);
  endproperty
  a_wday: assert property (p_wday) else $error("weekday output wrong");

  property p_wday_rst;
    $rose(rst_n) |-> wdayEn_ff == 7'h1f;
  endproperty
  a_wday_rst: assert property (p_wday_rst) else $error("weekday reset value");

  property p_aux;
    $past(ce) && $past(rst_n) |->
      auxFlag == $past(auxFlagExpr) && canSharedFlag == $past(canFlagExpr);
  endproperty
  a_aux: assert property (p_aux) else $error("flag not following");

  property p_led;
    !metal_ff |-> ledDriveFlag == '0;
  endproperty
  a_led: assert property (p_led) else $error("LED driven on display variant");

  property p_bhold;
    s_axi_bvalid && !s_axi_bready && ce |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped early");

  c_write: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_daily: cover property (!cmdVar_ff[0] ##1 cmdVar_ff[0]);
  c_wday: cover property (cmdVar_ff[2] ##1 !cmdVar_ff[2]);
endmodule : tsf_time_setpoint

// [verif/tb.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end
// ==========================================================
// Bench for the time setpoints and flags.
module tb;
  logic        clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        ce, metal;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, ledAuxFlag, ledDriveFlag, ledFlagExpr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [5:0]  rtcSec, rtcMin;
  logic [4:0]  rtcHour, rtcDay, canSharedFlag, canFlagExpr;
  logic [2:0]  rtcWeekday;
  logic [6:0]  cmdVar;
  logic [15:0] auxFlag, auxFlagExpr;
  logic [28:0] e;
  int          bad_count, check_count, h, m, s, w, d, x;
  int          sp [7] = '{32'h80000, 32'h110000, 1, 12, 0, 0, 32'h1f};
  bit   [31:0] seed = 32'he166110e;

  tsf_time_setpoint tsf_time_setpoint_inst (.clk, .rst_n, .ce, .rtcSec, .rtcMin,
    .rtcHour, .rtcWeekday, .rtcDay, .auxFlagExpr, .canFlagExpr, .ledFlagExpr,
    .metalHousing(metal), .cmdVar, .auxFlag, .canSharedFlag, .ledAuxFlag, .ledDriveFlag,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  tsf_far_model far (.clk, .rtcSec, .rtcMin, .rtcHour, .rtcWeekday, .rtcDay,
    .auxFlagExpr, .canFlagExpr, .ledFlagExpr);

  function automatic bit [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic int tod(int q);
    return (q >> 16) * 3600 + (q >> 8 & 63) * 60 + (q & 63);
  endfunction : tod

  // Daily setpoints compare the whole time of day, so they hold until midnight.
  function automatic logic [6:0] expc();
    return {s == sp[5], m == sp[4], h == sp[3], d == sp[2], sp[6][w],
      h * 3600 + m * 60 + s >= tod(sp[1]), h * 3600 + m * 60 + s >= tod(sp[0])};
  endfunction : expc

  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    bit ta, tw;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dt;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(ta && tw)) begin
      @(posedge clk);
      if (s_axi_awready && !ta) begin ta = 1; s_axi_awvalid <= 1'b0; end
      if (s_axi_wready && !tw) begin tw = 1; s_axi_wvalid <= 1'b0; end
    end
    while (!s_axi_bvalid) @(posedge clk);
    `CHK(s_axi_bresp, 2'h0)
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    bad_count++;
    end_sim();
  end

  initial
  begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {ce, metal} = 2'h3;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 7; i++) begin rd(8'(i * 4)); `CHK(v, sp[i]) end
    wr(8'h00, 32'h180000);
    rd(8'h00); `CHK(v, sp[0])
    rd(8'h40); `CHK({r, v}, 34'h200000000)
    for (int k = 0; k < 48; k++) begin
      for (int i = 0; i < 7 && k % 8 == 0; i++) begin
        x = i < 2 ? (xs() % 24) << 16 | (xs() % 60) << 8 | xs() % 60 : i == 2 ? xs() % 31 + 1
          : i == 3 ? xs() % 24 : i < 6 ? xs() % 60 : xs() % 128;
        wr(8'(i * 4), x);
        sp[i] = x;
      end
      x = xs();
      h = x[0] ? sp[3] : xs() % 24;
      m = x[1] ? sp[4] : xs() % 60;
      s = x[2] ? sp[5] : xs() % 60;
      d = x[3] ? sp[2] : xs() % 31 + 1;
      w = xs() % 8;
      if (x[5:4] == 2'h3) begin h = sp[0] >> 16; m = sp[0] >> 8 & 63; s = sp[0] & 63 - x[6]; end
      e = 29'(xs());
      far.put(h, m, s, w, d, e);
      repeat (3) @(posedge clk);
      `CHK(cmdVar, expc())
      `CHK({ledDriveFlag, ledAuxFlag, canSharedFlag, auxFlag}, {e[28:21], e})
    end
    rd(8'h1c); `CHK(v, {25'h0, expc()})
    rd(8'h20); `CHK(v, {e[28:21], 3'h0, e[20:0]})
    // With the clock enable low every output must keep its last value.
    x = expc();
    ce <= 1'b0;
    h = (h + 1) % 24;
    s = (s + 1) % 60;
    e = ~e;
    far.put(h, m, s, w, d, e);
    repeat (3) @(posedge clk);
    `CHK(cmdVar, 7'(x))
    `CHK(auxFlag, ~e[15:0])
    ce <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(cmdVar, expc())
    `CHK({canSharedFlag, auxFlag}, e[20:0])
    // A second reset on the display variant restores defaults and mutes ledDriveFlag, while ledAuxFlag keeps following.
    rst_n <= 1'b0;
    metal <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    sp = '{32'h80000, 32'h110000, 1, 12, 0, 0, 32'h1f};
    repeat (4) @(posedge clk);
    `CHK(cmdVar, expc())
    `CHK({ledDriveFlag, ledAuxFlag}, {8'h0, e[28:21]})
    end_sim();
  end
endmodule : tb

// [verif/tsf_far_model.sv]
`timescale 1ns/1ps
// ==========================================================
// Far side: calendar values set by put and logic-engine results.
module tsf_far_model (
  input  wire logic        clk,
  output logic      [5:0]  rtcSec,
  output logic      [5:0]  rtcMin,
  output logic      [4:0]  rtcHour,
  output logic      [2:0]  rtcWeekday,
  output logic      [4:0]  rtcDay,
  output logic      [15:0] auxFlagExpr,
  output logic      [4:0]  canFlagExpr,
  output logic      [7:0]  ledFlagExpr
);
  // Time jumps freely, so no comparator may rely on one-second steps.
  task automatic put(input int h, m, s, w, d, input logic [28:0] e);
    @(posedge clk);
    rtcHour <= 5'(h);
    rtcMin <= 6'(m);
    rtcSec <= 6'(s);
    rtcWeekday <= 3'(w);
    rtcDay <= 5'(d);
    {ledFlagExpr, canFlagExpr, auxFlagExpr} <= e;
  endtask : put

  initial
  begin
    {rtcHour, rtcMin, rtcSec, rtcWeekday, ledFlagExpr, canFlagExpr, auxFlagExpr} = '0;
    rtcDay = 5'h01;
  end
endmodule : tsf_far_model
